// ==== src/frame_sync_config_shadow.sv ====
// Configuration shadow registers applied to the sequencer at frame boundaries
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Black config edits flag transient frames, blkCfg1 edits also flag sync code corruption
// - Sync code edits corrupt only current frame
// - Test pattern edits corrupt one frame
// - Frame parameters move to active at boundaries
// - Window switch blanks frame, sends training
// - Subsample and binning change at frame start
// - Active window geometry edits flag corruption
// - Exposure one frame late, unless triggered master in sync mode
// - Gain at frame start, optional extra delay
// - Freeze controls at address 206
// - Frozen group keeps its active values
// - Black line count frozen when bit clear
// - Exposure set frozen when bit clear
// - Gain set frozen when bit clear
// - Window bit freezes masks, not geometry
// - Thirty-two windows, one enable bit each
// - Inactive window edits accepted silently
// - Black lines generated at each frame start with a nonzero count
// - Programmable black target, clip below zero
// - Sixty-four column offsets per kernel
// - Reset leaves only window zero enabled
// - Nine-bit address, sixteen-bit data
module frame_sync_config_shadow
    import frame_sync_pkg::*;
#(
    parameter int KERNEL_COLS = 64,
    parameter int PIX_W = 10,
    parameter int BLACK_TRANSIENT_FRAMES = 2
)(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [8:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire logic frameStart,
    input wire logic lineEnd,
    input wire logic calOffsetWe,
    input wire logic [5:0] calOffsetIdx,
    input wire logic [PIX_W-1:0] calOffsetVal,
    input wire logic [5:0] pixelColumn,
    input wire logic [PIX_W-1:0] pixelIn,
    output logic [PIX_W-1:0] pixelOut,
    output expo_t activeExpo,
    output gain_t activeGain,
    output win_t activeWin,
    output logic [7:0] activeBlackLines,
    output logic sendTraining,
    output logic blackLineActive,
    output logic blackLineGated,
    output logic blackTransient,
    output logic syncCodeCorrupt,
    output logic testPatternCorrupt,
    output logic windowCorrupt
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // Black target is a slice of one 16-bit word, so PIX_W stops at 16
    if (KERNEL_COLS != 64 || PIX_W < 2 || PIX_W > 16 || BLACK_TRANSIENT_FRAMES < 1
        || BLACK_TRANSIENT_FRAMES > 7)
    begin : g_badParam
        $error("frame_sync_config_shadow: unsupported parameters");
    end

    // ------------------------------------------------------------
    // Programmed registers
    // ------------------------------------------------------------
    logic [15:0] blkCfg0; // Black filter setup and target
    logic [15:0] blkCfg1; // Black offset setup, sync code select
    logic [15:0] seqCtrl; // Sequencer mode bits
    logic [15:0] progLo; // Programmed window mask, low half
    logic [15:0] progHi; // Programmed window mask, high half
    logic [15:0] blkLines; // Black line count and count of leading gated lines
    logic [15:0] progMult; // Timer multiplier
    logic [15:0] progLen; // Frame period length
    logic [15:0] progExp; // Exposure
    logic [15:0] gainReg; // Gain fields and latency compensation
    logic [15:0] syncCfg; // Per-group freeze controls
    logic [15:0] syncCodes [11]; // Sync code words
    logic [15:0] testRegs [7]; // Test pattern words
    logic [15:0] geom [96]; // Window geometry, three words each
    logic [PIX_W-1:0] colOffset [KERNEL_COLS]; // Per-column offsets

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire inSync = regAddr >= ADDR_SYNC_FIRST && regAddr <= ADDR_SYNC_LAST;
    wire inTest = regAddr >= ADDR_TEST_FIRST && regAddr <= ADDR_TEST_LAST;
    wire inGeom = regAddr >= ADDR_GEOM_FIRST && regAddr <= ADDR_GEOM_LAST;
    wire [8:0] syncIdx = regAddr - ADDR_SYNC_FIRST;
    wire [8:0] testIdx = regAddr - ADDR_TEST_FIRST;
    wire [8:0] geomIdx = regAddr - ADDR_GEOM_FIRST;
    wire [8:0] geomWin = geomIdx / 9'd3;
    wire acquiring = seqCtrl[BIT_SEQ_EN];
    wire [31:0] liveMask = {activeWin.windowEnableMaskHi,
                            activeWin.windowEnableMaskLo};
    wire wrBlack = regWrite && (regAddr == ADDR_BLK_CFG0
                   || regAddr == ADDR_BLK_CFG1 || regAddr == ADDR_BLK_LINES);
    wire wrSync = regWrite && (inSync || regAddr == ADDR_BLK_CFG1);
    wire wrTest = regWrite && inTest;
    wire wrLiveGeom = regWrite && inGeom && liveMask[geomWin[4:0]];

    // ------------------------------------------------------------
    // Freeze controls and derived modes
    // ------------------------------------------------------------
    wire syncBlack = syncCfg[BIT_SYNC_BLACK];
    wire syncExpo = syncCfg[BIT_SYNC_EXPO];
    wire syncGain = syncCfg[BIT_SYNC_GAIN];
    wire syncWin = syncCfg[BIT_SYNC_WIN];
    // No latency only in triggered master with sync mode
    wire noExpoLat = seqCtrl[BIT_TRIGGERED] && !seqCtrl[BIT_SLAVE]
                     && seqCtrl[BIT_EXPO_SYNC_MODE];
    wire gainLatComp = gainReg[BIT_GAIN_LAT_COMP];
    wire expo_t progExpo = '{progMult, progLen, progExp};
    wire gain_t progGain = '{gainReg[12:8], gainReg[7:0]};
    wire win_t progWin = '{progLo, progHi, seqCtrl[BIT_SUBSAMPLE],
                           seqCtrl[BIT_BINNING]};
    wire maskChange = progLo != activeWin.windowEnableMaskLo
                      || progHi != activeWin.windowEnableMaskHi;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // word-wide host writes
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            blkCfg0 <= RST_ZERO;
            blkCfg1 <= RST_ZERO;
            seqCtrl <= RST_ZERO;
            progLo <= RST_WIN_LO;
            progHi <= RST_WIN_HI;
            blkLines <= RST_BLK_LINES;
            progMult <= RST_ZERO;
            progLen <= RST_ZERO;
            progExp <= RST_ZERO;
            gainReg <= RST_ZERO;
            syncCfg <= RST_SYNC_CFG;
        end
        else if (regWrite)
        begin
            // Plain decode, unmapped writes fall through
            case (regAddr)
                ADDR_BLK_CFG0: blkCfg0 <= regWrData;
                ADDR_BLK_CFG1: blkCfg1 <= regWrData;
                ADDR_SEQ_CTRL: seqCtrl <= regWrData;
                ADDR_WIN_LO: progLo <= regWrData;
                ADDR_WIN_HI: progHi <= regWrData;
                ADDR_BLK_LINES: blkLines <= regWrData;
                ADDR_MULT_TIMER: progMult <= regWrData;
                ADDR_FRAME_LEN: progLen <= regWrData;
                ADDR_EXPOSURE: progExp <= regWrData;
                ADDR_GAIN: gainReg <= regWrData;
                ADDR_SYNC_CFG: syncCfg <= regWrData;
                default: ;
            endcase
        end
    end

    // Array storage, no reset needed for data words
    // geometry always accepted
    always_ff @(posedge sys_clk)
    begin
        if (regWrite && inSync)
            syncCodes[syncIdx[3:0]] <= regWrData;
        if (regWrite && inTest)
            testRegs[testIdx[2:0]] <= regWrData;
        if (regWrite && inGeom)
            geom[geomIdx[6:0]] <= regWrData;
        if (calOffsetWe)
            colOffset[calOffsetIdx] <= calOffsetVal;
    end

    // ------------------------------------------------------------
    // Read back, one cycle later
    // ------------------------------------------------------------
    wire [15:0] statusWord = {9'h000, blackLineActive, windowCorrupt,
        testPatternCorrupt, syncCodeCorrupt, blackTransient,
        sendTraining, acquiring};
    logic [15:0] rdMux; // Selected read word
    always_comb
    begin
        rdMux = 16'h0000;
        if (inSync)
            rdMux = syncCodes[syncIdx[3:0]];
        else if (inTest)
            rdMux = testRegs[testIdx[2:0]];
        else if (inGeom)
            rdMux = geom[geomIdx[6:0]];
        else
        begin
            case (regAddr)
                ADDR_BLK_CFG0: rdMux = blkCfg0;
                ADDR_BLK_CFG1: rdMux = blkCfg1;
                ADDR_SEQ_CTRL: rdMux = seqCtrl;
                ADDR_WIN_LO: rdMux = progLo;
                ADDR_WIN_HI: rdMux = progHi;
                ADDR_BLK_LINES: rdMux = blkLines;
                ADDR_MULT_TIMER: rdMux = progMult;
                ADDR_FRAME_LEN: rdMux = progLen;
                ADDR_EXPOSURE: rdMux = progExp;
                ADDR_GAIN: rdMux = gainReg;
                ADDR_SYNC_CFG: rdMux = syncCfg;
                ADDR_STATUS: rdMux = statusWord;
                default: rdMux = 16'h0000;
            endcase
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            regRdData <= 16'h0000;
        else
            regRdData <= regRead ? rdMux : 16'h0000;
    end

    // ------------------------------------------------------------
    // Active set transfer at frame start
    // ------------------------------------------------------------
    expo_t stageExpo; // Exposure held one frame for latency
    gain_t stageGain; // Gain held one frame for alignment
    // copy only on the frame-start pulse
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stageExpo <= '0;
            activeExpo <= '0;
            stageGain <= '0;
            activeGain <= '0;
            activeWin <= '{RST_WIN_LO, RST_WIN_HI, 1'b0, 1'b0};
            activeBlackLines <= RST_BLK_LINES[7:0];
        end
        else if (frameStart)
        begin
            // exposure path, frozen when bit clear
            if (syncExpo)
            begin
                stageExpo <= progExpo;
                activeExpo <= noExpoLat ? progExpo : stageExpo;
            end
            // gain path, frozen when bit clear
            if (syncGain)
            begin
                stageGain <= progGain;
                activeGain <= gainLatComp ? stageGain : progGain;
            end
            if (syncWin)
                activeWin <= progWin;
            if (syncBlack)
                activeBlackLines <= blkLines[7:0];
        end
    end

    // ------------------------------------------------------------
    // Frame blank and corruption flags
    // ------------------------------------------------------------
    logic [2:0] blackLeft; // Frames left in black transient
    // Set wins over the frame-start clear in the corruption and transient flags
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sendTraining <= 1'b0;
            syncCodeCorrupt <= 1'b0;
            testPatternCorrupt <= 1'b0;
            windowCorrupt <= 1'b0;
            blackLeft <= 3'd0;
            blackTransient <= 1'b0;
        end
        else
        begin
            // blank the frame in which the switch lands
            if (frameStart)
                sendTraining <= syncWin && maskChange && acquiring;
            if (wrSync && acquiring)
                syncCodeCorrupt <= 1'b1;
            else if (frameStart)
                syncCodeCorrupt <= 1'b0;
            if (wrTest && acquiring)
                testPatternCorrupt <= 1'b1;
            else if (frameStart)
                testPatternCorrupt <= 1'b0;
            // live window edits may corrupt a frame
            if (wrLiveGeom && acquiring)
                windowCorrupt <= 1'b1;
            else if (frameStart)
                windowCorrupt <= 1'b0;
            // flag a run of frames, acquisition goes on
            if (wrBlack && acquiring)
            begin
                blackLeft <= 3'(BLACK_TRANSIENT_FRAMES);
                blackTransient <= 1'b1;
            end
            else if (frameStart && blackLeft != 3'd0)
            begin
                blackLeft <= blackLeft - 3'd1;
                blackTransient <= blackLeft != 3'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Black line generator
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_BLACK = 3'b010,
        S_IMAGE = 3'b100
    } line_state_t;
    line_state_t lineState; // Current phase of the frame
    logic [7:0] linesDone; // Black lines emitted so far
    wire lastBlack = linesDone + 8'd1 >= activeBlackLines;
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lineState <= S_IDLE;
            linesDone <= 8'd0;
            blackLineActive <= 1'b0;
            blackLineGated <= 1'b0;
        end
        else if (frameStart)
        begin
            // Restart even mid-frame, the sequencer owns timing
            linesDone <= 8'd0;
            lineState <= (activeBlackLines != 8'd0) ? S_BLACK : S_IMAGE;
            blackLineActive <= activeBlackLines != 8'd0;
            blackLineGated <= blkLines[12:8] != 5'd0;
        end
        else
        begin
            case (lineState)
                S_BLACK:
                begin
                    if (lineEnd)
                    begin
                        linesDone <= linesDone + 8'd1;
                        blackLineGated <= {3'd0, blkLines[12:8]} > linesDone + 8'd1;
                        if (lastBlack)
                        begin
                            lineState <= S_IMAGE;
                            blackLineActive <= 1'b0;
                            blackLineGated <= 1'b0;
                        end
                    end
                end
                S_IMAGE: ;
                S_IDLE: ;
                default: lineState <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Column offset and black target correction
    // ------------------------------------------------------------
    wire [PIX_W-1:0] blackTarget = blkCfg0[PIX_W-1:0];
    wire [PIX_W+1:0] corrSum = {2'b00, pixelIn} + {2'b00, blackTarget}
                               - {2'b00, colOffset[pixelColumn]};
    wire clipLow = corrSum[PIX_W+1];
    wire clipHigh = !clipLow && corrSum[PIX_W];
    // offset per column, clipped at zero
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            pixelOut <= '0;
        else if (clipLow)
            pixelOut <= '0;
        else if (clipHigh)
            pixelOut <= '1;
        else
            pixelOut <= corrSum[PIX_W-1:0];
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_expoFrozen;
        @(posedge sys_clk) disable iff (!arst_n)
        frameStart && !syncExpo |=> $stable(activeExpo);
    endproperty
    a_expoFrozen: assert property (p_expoFrozen)
        else $error("exposure changed while frozen");

    property p_gainFrozen;
        @(posedge sys_clk) disable iff (!arst_n)
        frameStart && !syncGain |=> $stable(activeGain);
    endproperty
    a_gainFrozen: assert property (p_gainFrozen)
        else $error("gain changed while frozen");

    property p_winMidFrame;
        @(posedge sys_clk) disable iff (!arst_n)
        !frameStart |=> $stable(activeWin) && $stable(activeBlackLines);
    endproperty
    a_winMidFrame: assert property (p_winMidFrame)
        else $error("active set changed between frame starts");

    property p_switchBlank;
        @(posedge sys_clk) disable iff (!arst_n)
        frameStart && syncWin && maskChange && acquiring |=> sendTraining;
    endproperty
    a_switchBlank: assert property (p_switchBlank)
        else $error("window switch did not blank frame");

    property p_syncClear;
        @(posedge sys_clk) disable iff (!arst_n)
        frameStart && !wrSync |=> !syncCodeCorrupt;
    endproperty
    a_syncClear: assert property (p_syncClear)
        else $error("sync code flag outlived its frame");

    property p_testSet;
        @(posedge sys_clk) disable iff (!arst_n)
        wrTest && acquiring |=> testPatternCorrupt;
    endproperty
    a_testSet: assert property (p_testSet)
        else $error("test pattern edit not flagged");

    property p_liveGeom;
        @(posedge sys_clk) disable iff (!arst_n)
        wrLiveGeom && acquiring |=> windowCorrupt ##1 (windowCorrupt || $past(frameStart));
    endproperty
    a_liveGeom: assert property (p_liveGeom)
        else $error("live window edit not flagged");

    property p_blackStart;
        @(posedge sys_clk) disable iff (!arst_n)
        frameStart && activeBlackLines != 8'd0 |=> blackLineActive;
    endproperty
    a_blackStart: assert property (p_blackStart)
        else $error("no black line at frame start");

    property p_expoNoLat;
        @(posedge sys_clk) disable iff (!arst_n)
        frameStart && syncExpo && noExpoLat |=> activeExpo == $past(progExpo);
    endproperty
    a_expoNoLat: assert property (p_expoNoLat)
        else $error("exposure latency not removed");
endmodule
`default_nettype wire

// ==== src/frame_sync_pkg.sv ====
// Shared constants and types for the frame-synchronised configuration shadow
package frame_sync_pkg;
    // ------------------------------------------------------------
    // Register addresses (9-bit word addresses)
    // ------------------------------------------------------------
    localparam logic [8:0] ADDR_BLK_CFG0 = 9'h080;
    localparam logic [8:0] ADDR_BLK_CFG1 = 9'h081;
    localparam logic [8:0] ADDR_SYNC_FIRST = 9'h074;
    localparam logic [8:0] ADDR_SYNC_LAST = 9'h07E;
    localparam logic [8:0] ADDR_TEST_FIRST = 9'h090;
    localparam logic [8:0] ADDR_TEST_LAST = 9'h096;
    localparam logic [8:0] ADDR_SEQ_CTRL = 9'h0C0;
    localparam logic [8:0] ADDR_WIN_LO = 9'h0C3;
    localparam logic [8:0] ADDR_WIN_HI = 9'h0C4;
    localparam logic [8:0] ADDR_BLK_LINES = 9'h0C5;
    localparam logic [8:0] ADDR_MULT_TIMER = 9'h0C7;
    localparam logic [8:0] ADDR_FRAME_LEN = 9'h0C8;
    localparam logic [8:0] ADDR_EXPOSURE = 9'h0C9;
    localparam logic [8:0] ADDR_GAIN = 9'h0CC;
    localparam logic [8:0] ADDR_SYNC_CFG = 9'h0CE;
    localparam logic [8:0] ADDR_STATUS = 9'h0CF;
    localparam logic [8:0] ADDR_GEOM_FIRST = 9'h100;
    localparam logic [8:0] ADDR_GEOM_LAST = 9'h15F;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_SEQ_EN = 0;
    localparam int BIT_TRIGGERED = 4;
    localparam int BIT_SLAVE = 5;
    localparam int BIT_SUBSAMPLE = 7;
    localparam int BIT_BINNING = 8;
    localparam int BIT_EXPO_SYNC_MODE = 11;
    localparam int BIT_SYNC_CODE_CFG = 13;
    localparam int BIT_GAIN_LAT_COMP = 13;
    localparam int BIT_SYNC_BLACK = 0;
    localparam int BIT_SYNC_EXPO = 1;
    localparam int BIT_SYNC_GAIN = 2;
    localparam int BIT_SYNC_WIN = 3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WIN_LO = 16'h0001;
    localparam logic [15:0] RST_WIN_HI = 16'h0000;
    localparam logic [15:0] RST_BLK_LINES = 16'h0001;
    localparam logic [15:0] RST_SYNC_CFG = 16'h000F;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    // ------------------------------------------------------------
    // Grouped active configuration
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] multTimer;
        logic [15:0] framePeriodLen;
        logic [15:0] exposure;
    } expo_t;
    typedef struct packed {
        logic [4:0] muxGainSw;
        logic [7:0] afeGain;
    } gain_t;
    typedef struct packed {
        logic [15:0] windowEnableMaskLo;
        logic [15:0] windowEnableMaskHi;
        logic subsample;
        logic binning;
    } win_t;
endpackage

// ==== test/frame_sync_config_shadow_test.sv ====
// Self-checking bench for the configuration shadow
`timescale 1ns/1ps
`default_nettype none
module frame_sync_config_shadow_test
    import frame_sync_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic arst_n;
    logic [8:0] regAddr;
    logic [15:0] regWrData, regRdData;
    logic regWrite, regRead, frameStart, lineEnd, calOffsetWe, rdSeen;
    logic [6:0] flags; // Status outputs, training in bit 1
    logic [5:0] calOffsetIdx, pixelColumn;
    logic [9:0] calOffsetVal, pixelIn, pixelOut;
    expo_t activeExpo;
    gain_t activeGain;
    win_t activeWin;
    logic [7:0] activeBlackLines;
    logic [31:0] seed = 32'h0274EF4E;
    logic [31:0] v;
    logic [15:0] expQ[$];
    int probe = 0;
    int errTotal = 0;
    int totalChecks = 0;
    // Output picked by the probe code
    wire [15:0] probeVal = probe == 1 ? activeExpo.exposure :
        probe == 2 ? {3'h0, activeGain} :
        probe == 6 ? {9'h000, flags} :
        probe == 3 ? activeWin.windowEnableMaskLo :
        probe == 4 ? {8'h00, activeBlackLines} : {6'h00, pixelOut};
    always #2 sys_clk = ~sys_clk;
    host_ctrl_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead));
    frame_sync_config_shadow uut (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .frameStart(frameStart), .lineEnd(lineEnd),
        .calOffsetWe(calOffsetWe), .calOffsetIdx(calOffsetIdx), .calOffsetVal(calOffsetVal),
        .pixelColumn(pixelColumn), .pixelIn(pixelIn), .pixelOut(pixelOut),
        .activeExpo(activeExpo), .activeGain(activeGain), .activeWin(activeWin),
        .activeBlackLines(activeBlackLines), .sendTraining(flags[1]),
        .blackLineActive(flags[6]), .blackLineGated(flags[0]), .blackTransient(flags[2]),
        .syncCodeCorrupt(flags[3]), .testPatternCorrupt(flags[4]), .windowCorrupt(flags[5]));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Fixed-seed xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        totalChecks++;
        if (seen !== want)
        begin
            errTotal++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic finishTest();
        if (errTotal == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rdx(input logic [8:0] a, input logic [15:0] want);
        expQ.push_back(want);
        host.rd(a);
    endtask
    // Probe is cleared by the watcher at the next falling edge
    task automatic chkOut(input int sel, input logic [15:0] want);
        expQ.push_back(want);
        probe = sel;
        @(posedge sys_clk);
    endtask
    task automatic frame();
        @(posedge sys_clk);
        frameStart <= 1'b1;
        @(posedge sys_clk);
        frameStart <= 1'b0;
    endtask
    // Watcher samples mid-cycle, clear of edge updates
    always @(posedge sys_clk)
        rdSeen <= regRead;
    always @(negedge sys_clk)
    begin
        if (rdSeen)
            check(regRdData, expQ.pop_front());
        if (probe != 0)
            check(probeVal, expQ.pop_front());
        probe = 0;
    end
    // Watchdog at 5000 cycles, far beyond the roughly 80 cycles needed
    initial
    begin
        #20000;
        errTotal++;
        finishTest();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {frameStart, lineEnd, calOffsetWe, calOffsetIdx, calOffsetVal, pixelColumn, pixelIn} = '0;
        rdSeen = 1'b0;
        arst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        chkOut(3, 16'h0001);
        chkOut(4, 16'h0001);
        rdx(ADDR_SYNC_CFG, 16'h000F);
        rdx(9'h1FF, 16'h0000);
        v = rnd();
        host.wr(ADDR_EXPOSURE, v[15:0]);
        frame();
        chkOut(1, 16'h0000);
        frame();
        chkOut(1, v[15:0]);
        host.wr(ADDR_GAIN, {3'h0, v[28:16]});
        frame();
        chkOut(2, {3'h0, v[28:16]});
        // Freeze every group, then upload a new set
        host.wr(ADDR_SYNC_CFG, 16'h0000);
        host.wr(ADDR_GAIN, 16'h00A5);
        host.wr(ADDR_EXPOSURE, 16'h1234);
        host.wr(ADDR_WIN_LO, v[15:0]);
        frame();
        chkOut(2, {3'h0, v[28:16]});
        chkOut(1, v[15:0]);
        chkOut(3, 16'h0001);
        host.wr(ADDR_SYNC_CFG, 16'h000F);
        frame();
        chkOut(2, 16'h00A5);
        chkOut(3, v[15:0]);
        host.wr(ADDR_BLK_LINES, 16'h0005);
        frame();
        chkOut(4, 16'h0005);
        // Target 32, column five offset 64
        host.wr(ADDR_BLK_CFG0, 16'h0020);
        calOffsetWe <= 1'b1;
        calOffsetIdx <= 6'd5;
        calOffsetVal <= 10'h040;
        @(posedge sys_clk);
        calOffsetWe <= 1'b0;
        pixelColumn <= 6'd5;
        pixelIn <= 10'h100;
        @(posedge sys_clk);
        pixelIn <= 10'h00A;
        chkOut(5, 16'h00E0);
        chkOut(5, 16'h0000);
        // Acquire as triggered master, exposure sync mode on
        host.wr(ADDR_SEQ_CTRL, 16'h0811);
        host.wr(ADDR_WIN_HI, 16'h0001);
        frame();
        chkOut(6, 16'h0042);
        rdx(ADDR_STATUS, 16'h0043);
        // Live edits: window 16 geometry, sync, test, exposure, black
        host.wr(9'h130, 16'h0000);
        host.wr(ADDR_SYNC_FIRST, 16'h0000);
        host.wr(ADDR_TEST_FIRST, 16'h0000);
        host.wr(ADDR_EXPOSURE, 16'h5678);
        host.wr(ADDR_BLK_LINES, 16'h0102);
        chkOut(6, 16'h007E);
        frame();
        // Two black lines, first one gated
        lineEnd <= 1'b1;
        chkOut(6, 16'h0045);
        lineEnd <= 1'b0;
        chkOut(6, 16'h0044);
        lineEnd <= 1'b1;
        chkOut(1, 16'h5678);
        lineEnd <= 1'b0;
        chkOut(6, 16'h0004);
        frame();
        chkOut(6, 16'h0041);
        finishTest();
    end
endmodule
`default_nettype wire

// ==== test/host_ctrl_model.sv ====
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
    input wire logic sys_clk,
    output logic [8:0] regAddr,
    output logic [15:0] regWrData,
    output logic regWrite,
    output logic regRead
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Idle bus at time zero
    initial {regAddr, regWrData, regWrite, regRead} = '0;
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        // Released data inverted so stale values never look valid
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [8:0] a);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        regAddr <= ~a;
    endtask
endmodule
`default_nettype wire
